// ==== include/adc_pkt_cfg.svh ====
// Register offsets, field positions, reset values and counts of the sample packetiser
`ifndef ADC_PKT_CFG_SVH
`define ADC_PKT_CFG_SVH
// ==========================================================
// Converter registers, reached over the link
`define DEV_IN_LAST      6'h1C
`define DEV_GEN_CTRL     6'h20
`define IN_EN_BIT        0
`define IN_DEST_LSB      8
`define GEN_EN_BIT       0
`define GEN_CAL_BIT      1
`define GEN_SPP_LSB      8
`define GEN_WIDTH_LSB    16
`define GEN_DROP_BIT     24
`define SPP_RST          8'h01
`define WIDTH_RST        2'h1
`define DROP_RST         1'b1
`define WIDTH_8          2'h0
`define WIDTH_16         2'h1
`define WIDTH_RSVD       2'h2
`define WIDTH_32         2'h3
`define WARMUP_PULSES    3'h6
// ==========================================================
// Controller registers, reached over APB
`define CTL_DADDR        8'h00
`define CTL_WDATA        8'h04
`define CTL_CMD          8'h08
`define CTL_RDATA        8'h0C
`define CTL_STATUS       8'h10
`define CTL_MASK         8'h14
`define CTL_RX           8'h18
`define CTL_RXDEST       8'h1C
`define CMD_GO_BIT       0
`define CMD_WR_BIT       1
`define CMD_TRIG_BIT     2
`define ST_DONE_BIT      0
`define ST_PEND_BIT      1
`define ST_BYTE_BIT      2
`endif

// ==== include/adc_pkt_pkg.sv ====
// Types shared by both ends of the sample link
`default_nettype none
package adc_pkt_pkg;
    typedef enum logic [1:0] {PH_IDLE, PH_CONV, PH_SEND} phase_t;

    typedef struct packed {
        logic [7:0][23:0] in_dest;
        logic [7:0]       in_en;
        logic             en;
        logic             cal;
        logic [7:0]       spp;
        logic [1:0]       width;
        logic             dropped;
        logic [2:0]       warm;
        logic [7:0]       pend;
        logic [7:0]       close;
        logic [7:0]       open;
        logic             close_req;
        logic [7:0][7:0]  cnt;
        phase_t           phase;
        logic [2:0]       cur;
        logic [31:0]      word;
        logic [2:0]       bleft;
        logic             last;
        logic             reg_ack;
        logic [31:0]      reg_rdata;
        logic             pkt_valid;
        logic [7:0]       pkt_data;
        logic [23:0]      pkt_dest;
        logic             pkt_end;
        logic             pkt_token;
    } dev_state_t;

    typedef struct packed {
        logic [5:0]  dev_addr;
        logic [31:0] dev_wdata;
        logic [31:0] dev_rdata;
        logic        req;
        logic        wr;
        logic        trig;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic [7:0]  rx_byte;
        logic        rx_end;
        logic        rx_tok;
        logic        rx_full;
        logic [23:0] rx_dest;
        logic        pkt_ready;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        irq;
    } ctl_state_t;
endpackage
`default_nettype wire

// ==== include/adc_link_if.sv ====
// Link between the converter packetiser and its controller
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
    logic        trig;
    logic        reg_req;
    logic        reg_wr;
    logic [5:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_ack;
    logic [31:0] reg_rdata;
    logic        pkt_valid;
    logic [7:0]  pkt_data;
    logic [23:0] pkt_dest;
    logic        pkt_end;
    logic        pkt_token;
    logic        pkt_ready;

    modport dev (input trig, reg_req, reg_wr, reg_addr, reg_wdata, pkt_ready,
                 output reg_ack, reg_rdata, pkt_valid, pkt_data, pkt_dest, pkt_end, pkt_token);
    modport ctl (output trig, reg_req, reg_wr, reg_addr, reg_wdata, pkt_ready,
                 input reg_ack, reg_rdata, pkt_valid, pkt_data, pkt_dest, pkt_end, pkt_token);
endinterface
`default_nettype wire

// ==== hdl/sample_shaper.sv ====
// Left-aligns one conversion result into the selected sample width
`timescale 1ns/1ps
`default_nettype none
`include "adc_pkt_cfg.svh"
module sample_shaper (
    input  wire logic [1:0]  width,
    input  wire logic [11:0] value,
    output logic      [31:0] word,
    output logic      [2:0]  nbytes
);
    always_comb begin
        unique case (width)
            `WIDTH_8: begin
                word   = {value[11:4], 24'h000000};
                nbytes = 3'h1;
            end
            `WIDTH_32: begin
                word   = {value, 20'h00000};
                nbytes = 3'h4;
            end
            // Reserved code never reaches here; it is refused at write time
            default: begin
                word   = {value, 4'h0, 16'h0000};
                nbytes = 3'h2;
            end
        endcase
    end
endmodule // sample_shaper
`default_nettype wire

// ==== hdl/adc_packet_device.sv ====
// Converter end: control registers, warm-up gating and sample packetiser
// ==========================================================
//
// Decided for this implementation: register access over the link, not an APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_pkt_cfg.svh"
module adc_packet_device (
    input  wire logic        pclk,
    input  wire logic        presetn,
    adc_link_if.dev          link,
    input  wire logic [11:0] conv_data,
    output logic      [2:0]  conv_sel,
    output logic             cal_ref,
    output logic             conv_enable
);
    adc_pkt_pkg::dev_state_t s_r;
    adc_pkt_pkg::dev_state_t s_nxt;
    logic [31:0]             shaped;
    logic [2:0]              shaped_n;
    logic                    out_free;
    logic [2:0]              idx;

    // Lowest set bit; inputs are served in ascending order
    function automatic logic [2:0] first_set(input logic [7:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    sample_shaper u_shaper (
        .width  (s_r.width),
        .value  (conv_data),
        .word   (shaped),
        .nbytes (shaped_n)
    );

    // ==========================================================
    // Next state
    always_comb begin
        s_nxt    = s_r;
        idx      = link.reg_addr[4:2];
        s_nxt.reg_ack = 1'b0;
        out_free = !s_r.pkt_valid || link.pkt_ready;
        if (s_r.pkt_valid && link.pkt_ready) begin
            s_nxt.pkt_valid = 1'b0;
        end

        // ==========================================================
        // Packet sequencer
        unique case (s_r.phase)
            adc_pkt_pkg::PH_IDLE: begin
                if (s_r.close_req) begin
                    // An access ends every open packet with a bare end token
                    s_nxt.close     = s_r.close | s_r.open;
                    s_nxt.open      = 8'h00;
                    s_nxt.cnt       = '0;
                    s_nxt.close_req = 1'b0;
                end else if (s_r.close != 8'h00) begin
                    if (out_free) begin
                        s_nxt.close[first_set(s_r.close)] = 1'b0;
                        s_nxt.pkt_valid = 1'b1;
                        s_nxt.pkt_token = 1'b1;
                        s_nxt.pkt_end   = 1'b1;
                        s_nxt.pkt_data  = 8'h00;
                        s_nxt.pkt_dest  = s_r.in_dest[first_set(s_r.close)];
                    end
                end else if (s_r.pend != 8'h00) begin
                    s_nxt.cur   = first_set(s_r.pend);
                    s_nxt.pend[first_set(s_r.pend)] = 1'b0;
                    s_nxt.phase = adc_pkt_pkg::PH_CONV;
                end
            end
            adc_pkt_pkg::PH_CONV: begin
                // conv_sel has stood one cycle, so conv_data now belongs to cur
                s_nxt.word  = shaped;
                s_nxt.bleft = shaped_n;
                s_nxt.last  = (s_r.spp != 8'h00)
                              && (8'(s_r.cnt[s_r.cur] + 8'h01) == s_r.spp);
                s_nxt.cnt[s_r.cur] = s_nxt.last ? 8'h00 : 8'(s_r.cnt[s_r.cur] + 8'h01);
                s_nxt.phase = adc_pkt_pkg::PH_SEND;
            end
            adc_pkt_pkg::PH_SEND: begin
                if (out_free) begin
                    s_nxt.pkt_valid = 1'b1;
                    s_nxt.pkt_token = 1'b0;
                    s_nxt.pkt_data  = s_r.word[31:24];
                    s_nxt.pkt_dest  = s_r.in_dest[s_r.cur];
                    s_nxt.pkt_end   = s_r.last && (s_r.bleft == 3'h1);
                    s_nxt.word      = {s_r.word[23:0], 8'h00};
                    s_nxt.bleft     = 3'(s_r.bleft - 3'h1);
                    if (s_r.bleft == 3'h1) begin
                        s_nxt.open[s_r.cur] = !s_r.last;
                        s_nxt.phase         = adc_pkt_pkg::PH_IDLE;
                    end
                end
            end
            // Unused phase code; fall back to idle rather than lock up
            default: begin
                s_nxt.phase = adc_pkt_pkg::PH_IDLE;
            end
        endcase

        // ==========================================================
        // Register access over the link
        // One access at a time; the request seen during the ack cycle is ignored
        if (link.reg_req && !s_r.reg_ack) begin
            s_nxt.reg_ack   = 1'b1;
            s_nxt.close_req = 1'b1;
            s_nxt.reg_rdata = 32'h00000000;
            if (link.reg_addr == `DEV_GEN_CTRL) begin
                s_nxt.reg_rdata[`GEN_EN_BIT]          = s_r.en;
                s_nxt.reg_rdata[`GEN_CAL_BIT]         = s_r.cal;
                s_nxt.reg_rdata[`GEN_SPP_LSB +: 8]    = s_r.spp;
                s_nxt.reg_rdata[`GEN_WIDTH_LSB +: 2]  = s_r.width;
                s_nxt.reg_rdata[`GEN_DROP_BIT]        = s_r.dropped;
                if (link.reg_wr) begin
                    s_nxt.en  = link.reg_wdata[`GEN_EN_BIT];
                    s_nxt.cal = link.reg_wdata[`GEN_CAL_BIT];
                    s_nxt.spp = link.reg_wdata[`GEN_SPP_LSB +: 8];
                    if (!s_r.en && link.reg_wdata[`GEN_EN_BIT]) begin
                        s_nxt.warm = 3'h0;
                    end
                    if (link.reg_wdata[`GEN_WIDTH_LSB +: 2] != `WIDTH_RSVD) begin
                        s_nxt.width = link.reg_wdata[`GEN_WIDTH_LSB +: 2];
                    end
                end else begin
                    s_nxt.dropped = 1'b0;
                end
            end else if (link.reg_addr <= `DEV_IN_LAST && link.reg_addr[1:0] == 2'h0) begin
                s_nxt.reg_rdata[`IN_DEST_LSB +: 24] = s_r.in_dest[idx];
                s_nxt.reg_rdata[`IN_EN_BIT]         = s_r.in_en[idx];
                if (link.reg_wr && !s_r.en) begin
                    s_nxt.in_dest[idx] = link.reg_wdata[`IN_DEST_LSB +: 24];
                    s_nxt.in_en[idx]   = link.reg_wdata[`IN_EN_BIT];
                end
            end
        end

        // ==========================================================
        // Trigger pulses; a drop set here wins over a clear by read
        if (link.trig && s_r.en) begin
            if (s_r.warm != `WARMUP_PULSES) begin
                // Warm-up pulses only count; nothing is queued for sending
                s_nxt.warm = 3'(s_r.warm + 3'h1);
            end else if (s_r.phase != adc_pkt_pkg::PH_IDLE || s_r.pend != 8'h00) begin
                s_nxt.dropped = 1'b1;
            end else begin
                s_nxt.pend = s_r.in_en;
            end
        end
        if (!s_r.en) begin
            s_nxt.pend = 8'h00;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r         <= '0;
            s_r.spp     <= `SPP_RST;
            s_r.width   <= `WIDTH_RST;
            // Drop flag starts set, so the first read reports it
            s_r.dropped <= `DROP_RST;
            s_r.phase   <= adc_pkt_pkg::PH_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs, straight from the state register
    assign link.reg_ack   = s_r.reg_ack;
    assign link.reg_rdata = s_r.reg_rdata;
    assign link.pkt_valid = s_r.pkt_valid;
    assign link.pkt_data  = s_r.pkt_data;
    assign link.pkt_dest  = s_r.pkt_dest;
    assign link.pkt_end   = s_r.pkt_end;
    assign link.pkt_token = s_r.pkt_token;
    assign conv_sel       = s_r.cur;
    assign cal_ref        = s_r.cal;
    assign conv_enable    = s_r.en;
endmodule // adc_packet_device
`default_nettype wire

// ==== hdl/adc_packet_ctrl.sv ====
// Controller end: APB registers, link commands, trigger pulses and packet receive
`timescale 1ns/1ps
`default_nettype none
`include "adc_pkt_cfg.svh"
module adc_packet_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    adc_link_if.ctl          link
);
    adc_pkt_pkg::ctl_state_t s_r;
    adc_pkt_pkg::ctl_state_t s_nxt;

    // ==========================================================
    // Next state
    always_comb begin
        s_nxt         = s_r;
        s_nxt.trig    = 1'b0;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;

        // Answer one cycle into the access phase
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h00000000;
            unique case (paddr)
                `CTL_DADDR:  s_nxt.prdata = {26'h0000000, s_r.dev_addr};
                `CTL_WDATA:  s_nxt.prdata = s_r.dev_wdata;
                `CTL_CMD:    s_nxt.prdata = {31'h00000000, s_r.req};
                `CTL_RDATA:  s_nxt.prdata = s_r.dev_rdata;
                `CTL_STATUS: s_nxt.prdata = {29'h00000000, s_r.status};
                `CTL_MASK:   s_nxt.prdata = {29'h00000000, s_r.mask};
                `CTL_RX:     s_nxt.prdata = {21'h000000, s_r.rx_full, s_r.rx_tok,
                                             s_r.rx_end, s_r.rx_byte};
                `CTL_RXDEST: s_nxt.prdata = {8'h00, s_r.rx_dest};
                default:     s_nxt.pslverr = 1'b1;
            endcase
        end

        // Effects only at the completing edge
        if (psel && penable && s_r.pready) begin
            if (pwrite) begin
                unique case (paddr)
                    `CTL_DADDR:  s_nxt.dev_addr  = pwdata[5:0];
                    `CTL_WDATA:  s_nxt.dev_wdata = pwdata;
                    `CTL_CMD: begin
                        // A new command while one is pending is ignored
                        if (pwdata[`CMD_GO_BIT] && !s_r.req) begin
                            s_nxt.req = 1'b1;
                            s_nxt.wr  = pwdata[`CMD_WR_BIT];
                        end
                        s_nxt.trig = pwdata[`CMD_TRIG_BIT];
                    end
                    `CTL_STATUS: s_nxt.status = s_r.status & ~pwdata[2:0];
                    `CTL_MASK:   s_nxt.mask   = pwdata[2:0];
                    default: begin
                    end
                endcase
            end else if (paddr == `CTL_RX) begin
                s_nxt.rx_full = 1'b0;
            end
        end

        // ==========================================================
        // Link events; each set wins over a clear in the same cycle
        if (link.reg_ack) begin
            s_nxt.req                = 1'b0;
            s_nxt.dev_rdata          = link.reg_rdata;
            s_nxt.status[`ST_DONE_BIT] = 1'b1;
        end
        if (link.pkt_valid && s_r.pkt_ready) begin
            s_nxt.rx_byte = link.pkt_data;
            s_nxt.rx_end  = link.pkt_end;
            s_nxt.rx_tok  = link.pkt_token;
            s_nxt.rx_dest = link.pkt_dest;
            s_nxt.rx_full = 1'b1;
            s_nxt.status[`ST_BYTE_BIT] = 1'b1;
            if (link.pkt_end) begin
                s_nxt.status[`ST_PEND_BIT] = 1'b1;
            end
        end
        // One-byte holding stage; a slow reader stalls the converter
        s_nxt.pkt_ready = !s_nxt.rx_full;
        s_nxt.irq       = |(s_nxt.status & s_nxt.mask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata         = s_r.prdata;
    assign pready         = s_r.pready;
    assign pslverr        = s_r.pslverr;
    assign irq            = s_r.irq;
    assign link.trig      = s_r.trig;
    assign link.reg_req   = s_r.req;
    assign link.reg_wr    = s_r.wr;
    assign link.reg_addr  = s_r.dev_addr;
    assign link.reg_wdata = s_r.dev_wdata;
    assign link.pkt_ready = s_r.pkt_ready;
endmodule // adc_packet_ctrl
`default_nettype wire

// ==== testbench/adc_link_checker.sv ====
// Concurrent checks on the link between packetiser and controller
`timescale 1ns/1ps
`default_nettype none
module adc_link_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        trig,
    input wire logic        reg_req,
    input wire logic        reg_wr,
    input wire logic [5:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_ack,
    input wire logic [31:0] reg_rdata,
    input wire logic        pkt_valid,
    input wire logic [7:0]  pkt_data,
    input wire logic [23:0] pkt_dest,
    input wire logic        pkt_end,
    input wire logic        pkt_token,
    input wire logic        pkt_ready
);
    // ==========================================
    // Shadow of width, enable, warm-up and byte count, decoded from link writes, trigger pulses and taken bytes
    logic [1:0] width_r;
    logic       en_r;
    logic [2:0] warm_r;
    logic [1:0] bcnt_r;
    logic [2:0] nb;
    logic       gen_wr;
    logic       rd_ack;
    assign gen_wr = reg_ack && reg_wr && reg_addr == 6'h20;
    assign rd_ack = reg_ack && !reg_wr;
    assign nb = (width_r == 2'h0) ? 3'h1 : (width_r == 2'h1) ? 3'h2 : 3'h4;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_r <= 2'h1;
            en_r    <= 1'b0;
            warm_r  <= 3'h0;
            bcnt_r  <= 2'h0;
        end else begin
            if (gen_wr && reg_wdata[17:16] != 2'h2) begin
                width_r <= reg_wdata[17:16];
            end
            if (gen_wr) begin
                en_r <= reg_wdata[0];
            end
            if (gen_wr && reg_wdata[0] && !en_r) begin
                warm_r <= 3'h0;
            end else if (trig && en_r && warm_r != 3'h6) begin
                warm_r <= warm_r + 3'h1;
            end
            if (pkt_valid && pkt_ready && !pkt_token) begin
                bcnt_r <= ({1'b0, bcnt_r} + 3'h1 == nb) ? 2'h0 : bcnt_r + 2'h1;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Properties
    a_ack_prompt: assert property (reg_req && !reg_ack |=> reg_ack)
        else $error("register request not answered next cycle");
    a_ack_single: assert property (reg_ack |=> !reg_ack)
        else $error("register answer longer than one cycle");
    a_in_reserved: assert property (rd_ack && reg_addr <= 6'h1C |-> reg_rdata[7:1] == 7'h0)
        else $error("input register reserved bits not zero");
    a_gen_fields: assert property (rd_ack && reg_addr == 6'h20 |-> reg_rdata[31:25] == 7'h0
        && reg_rdata[23:18] == 6'h0 && reg_rdata[7:2] == 6'h0 && reg_rdata[17:16] != 2'h2)
        else $error("general register reads a reserved value");
    a_pkt_hold: assert property (pkt_valid && !pkt_ready |=> pkt_valid
        && $stable({pkt_data, pkt_dest, pkt_end, pkt_token}))
        else $error("offered byte changed before it was taken");
    a_token_form: assert property (pkt_valid && pkt_token |-> pkt_end && pkt_data == 8'h0)
        else $error("end marker malformed");
    a_sample_len: assert property (pkt_valid && !pkt_token && pkt_end |-> {1'b0, bcnt_r} + 3'h1 == nb)
        else $error("packet ends inside a sample");
    a_pad_zero: assert property (pkt_valid && !pkt_token && width_r != 2'h0 && bcnt_r != 2'h0
        |-> pkt_data[3:0] == 4'h0 && (bcnt_r == 2'h1 || pkt_data == 8'h0))
        else $error("padding bits not zero");
    a_warm_silent: assert property (trig && en_r && warm_r < 3'h6 |=> !pkt_valid [*4])
        else $error("packet during warm-up");
    a_live_pulse: assert property (trig && en_r && warm_r == 3'h6 |-> ##[1:8] pkt_valid)
        else $error("no sample after warm-up");
endmodule // adc_link_checker
`default_nettype wire

// ==== testbench/adc_sample_packetizer_tb_top.sv ====
// Bench: both link ends, APB stimulus and byte scoreboard
`timescale 1ns/1ps
`default_nettype none
`include "adc_pkt_cfg.svh"
module adc_sample_packetizer_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [11:0] conv_data;
    logic [2:0]  conv_sel;
    logic        cal_ref;
    logic        conv_enable;
    logic [11:0] vals [8];
    logic [23:0] dest [8];
    logic [33:0] exp_q [$];
    logic [31:0] rd;
    logic [31:0] v;
    logic [1:0]  w;
    logic        err;
    int          bad_count;
    int          n_tests;
    int          seed;
    adc_link_if lk ();
    adc_packet_device adc_packet_device_i (.pclk(pclk), .presetn(presetn), .link(lk),
        .conv_data(conv_data), .conv_sel(conv_sel), .cal_ref(cal_ref), .conv_enable(conv_enable));
    adc_packet_ctrl adc_packet_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .link(lk));
    adc_link_checker adc_link_checker_i (.pclk(pclk), .presetn(presetn), .trig(lk.trig),
        .reg_req(lk.reg_req), .reg_wr(lk.reg_wr), .reg_addr(lk.reg_addr),
        .reg_wdata(lk.reg_wdata), .reg_ack(lk.reg_ack), .reg_rdata(lk.reg_rdata),
        .pkt_valid(lk.pkt_valid), .pkt_data(lk.pkt_data), .pkt_dest(lk.pkt_dest),
        .pkt_end(lk.pkt_end), .pkt_token(lk.pkt_token), .pkt_ready(lk.pkt_ready));
    // Converter result follows the selected input at once
    assign conv_data = vals[conv_sel];
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Device register access through the controller; polls done, then clears it
    task automatic dev(input logic wr, input logic [5:0] a, input logic [31:0] d);
        apb(1'b1, `CTL_DADDR, {26'h0, a});
        apb(1'b1, `CTL_WDATA, d);
        apb(1'b1, `CTL_CMD, {30'h0, wr, 1'b1});
        do apb(1'b0, `CTL_STATUS, 32'h0); while (rd[0] !== 1'b1);
        apb(1'b0, `CTL_RDATA, 32'h0);
        v = rd;
        apb(1'b1, `CTL_STATUS, 32'h1);
    endtask
    task automatic trig(input int n);
        repeat (n) apb(1'b1, `CTL_CMD, 32'h4);
    endtask
    task automatic drain(input int n);
        int got;
        got = 0;
        repeat (60) begin
            if (got < n) begin
                apb(1'b0, `CTL_RX, 32'h0);
                if (rd[10] === 1'b1) got++;
            end
        end
        chk(64'(got), 64'(n));
        chk(64'(exp_q.size()), 64'h0);
    endtask
    task automatic expect_in(input int i, input logic [1:0] wd, input logic endp);
        logic [31:0] word;
        int          nb;
        word = {vals[i], 20'h0};
        nb = (wd == 2'h0) ? 1 : (wd == 2'h1) ? 2 : 4;
        for (int b = 0; b < nb; b++) begin
            exp_q.push_back({1'b0, endp && (b == nb - 1), dest[i], word[31 - 8 * b -: 8]});
        end
    endtask
    // One trigger with fresh results on inputs 2 and 7, lowest index first
    task automatic shot(input logic [1:0] wd, input logic endp);
        vals[2] <= 12'($random(seed));
        vals[7] <= 12'($random(seed));
        @(posedge pclk);
        expect_in(2, wd, endp);
        expect_in(7, wd, endp);
        trig(1);
        drain((wd == 2'h0) ? 2 : (wd == 2'h1) ? 4 : 8);
    endtask
    task automatic warm_up();
        trig(6);
        repeat (10) @(posedge pclk);
        apb(1'b0, `CTL_RX, 32'h0);
        chk(rd[10], 1'b0);
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================
    // Scoreboard: every byte taken on the link against the oldest note
    always @(posedge pclk) begin
        if (lk.pkt_valid === 1'b1 && lk.pkt_ready === 1'b1) begin
            chk({lk.pkt_token, lk.pkt_end, lk.pkt_dest, lk.pkt_data},
                (exp_q.size() != 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF);
        end
    end
    initial begin
        #1_000_000;
        bad_count++;
        print_verdict();
    end
    initial begin
        seed = 960;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        for (int i = 0; i < 8; i++) begin
            vals[i] = 12'h0;
            dest[i] = 24'($random(seed));
        end
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        dev(1'b0, 6'h20, 32'h0);
        chk(v, 32'h0101_0100);
        dev(1'b0, 6'h20, 32'h0);
        chk(v, 32'h0001_0100);
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
        dev(1'b1, 6'h1C, {dest[7], 8'hFF});
        dev(1'b1, 6'h08, {dest[2], 8'h01});
        dev(1'b1, 6'h20, 32'h0001_0101);
        dev(1'b1, 6'h1C, 32'h0);
        dev(1'b0, 6'h1C, 32'h0);
        chk(v, {dest[7], 8'h01});
        chk(conv_enable, 1'b1);
        warm_up();
        for (int k = 0; k < 3; k++) begin
            w = (k == 2) ? 2'h3 : 2'(k);
            dev(1'b1, 6'h20, {14'h0, w, 16'h0101});
            shot(w, 1'b1);
        end
        dev(1'b1, 6'h20, 32'h0002_0101);
        dev(1'b0, 6'h20, 32'h0);
        chk(v, 32'h0003_0101);
        dev(1'b1, 6'h20, 32'h0000_0201);
        shot(2'h0, 1'b0);
        shot(2'h0, 1'b1);
        dev(1'b1, 6'h20, 32'h0000_0001);
        shot(2'h0, 1'b0);
        exp_q.push_back({2'h3, dest[2], 8'h0});
        exp_q.push_back({2'h3, dest[7], 8'h0});
        dev(1'b0, 6'h20, 32'h0);
        drain(2);
        dev(1'b1, 6'h20, 32'h0000_0101);
        vals[2] <= 12'($random(seed));
        vals[7] <= 12'($random(seed));
        @(posedge pclk);
        expect_in(2, 2'h0, 1'b1);
        expect_in(7, 2'h0, 1'b1);
        trig(2);
        drain(2);
        dev(1'b0, 6'h20, 32'h0);
        chk(v, 32'h0100_0101);
        dev(1'b0, 6'h20, 32'h0);
        chk(v, 32'h0000_0101);
        apb(1'b1, `CTL_MASK, 32'h4);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, `CTL_STATUS, 32'h4);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        dev(1'b1, 6'h20, 32'h0000_0103);
        chk(cal_ref, 1'b1);
        shot(2'h0, 1'b1);
        dev(1'b1, 6'h20, 32'h0000_0100);
        chk(conv_enable, 1'b0);
        dev(1'b1, 6'h20, 32'h0000_0101);
        warm_up();
        shot(2'h0, 1'b1);
        print_verdict();
    end
endmodule // adc_sample_packetizer_tb_top
`default_nettype wire
